//--- rtl/bopbr_defines.vh
// Operation codes, field widths, reset values and cycle counts
`ifndef BOPBR_DEFINES_VH
`define BOPBR_DEFINES_VH

// ************************************************************
// Operation select codes
// ************************************************************
`define BOPBR_OP_NONE        3'h0
`define BOPBR_OP_CLEAR_FILE  3'h1
`define BOPBR_OP_DEC_FILE    3'h2
`define BOPBR_OP_CLEAR_WORK  3'h3
`define BOPBR_OP_DEC_SKIP    3'h4
`define BOPBR_OP_INC_SKIP    3'h5
`define BOPBR_OP_BRANCH      3'h6
`define BOPBR_OP_OR_LITERAL  3'h7

// ************************************************************
// Widths and field positions
// ************************************************************
`define BOPBR_DATA_W         8
`define BOPBR_FADDR_W        7
`define BOPBR_FILE_DEPTH     128
`define BOPBR_PC_W           15
`define BOPBR_LIT_W          11
`define BOPBR_LATCH_W        7
`define BOPBR_LATCH_HI       6
`define BOPBR_LATCH_LO       3

// Destination bit values
`define BOPBR_DEST_WORK      1'b0
`define BOPBR_DEST_FILE      1'b1

// ************************************************************
// Reset values
// ************************************************************
`define BOPBR_RST_DATA       8'h00
`define BOPBR_RST_PC         15'h0000
`define BOPBR_RST_ZERO       1'b0

// ************************************************************
// Cycle counts
// ************************************************************
`define BOPBR_CYCLES_LONG    2

`endif

//--- rtl/bopbr_alu.v
// Result, destination, zero flag and skip decision for one operation
`timescale 1ns/1ps
`include "bopbr_defines.vh"

module bopbr_alu (
	op_sel,
	work_val,
	file_val,
	lit_val,
	dest_sel,
	result,
	write_work,
	write_file,
	update_zero,
	zero_val,
	skip_next
);
	input  wire [2:0]                 op_sel;
	input  wire [`BOPBR_DATA_W-1:0]   work_val;
	input  wire [`BOPBR_DATA_W-1:0]   file_val;
	input  wire [`BOPBR_DATA_W-1:0]   lit_val;
	input  wire                       dest_sel;
	output reg  [`BOPBR_DATA_W-1:0]   result;
	output reg                        write_work;
	output reg                        write_file;
	output reg                        update_zero;
	output reg                        zero_val;
	output reg                        skip_next;

	function is_zero;
		input [`BOPBR_DATA_W-1:0] v;
		begin
			is_zero = (v == `BOPBR_RST_DATA);
		end
	endfunction

	always @* begin
		result      = `BOPBR_RST_DATA;
		write_work  = 1'b0;
		write_file  = 1'b0;
		update_zero = 1'b0;
		zero_val    = 1'b0;
		skip_next   = 1'b0;
		case (op_sel)
		`BOPBR_OP_CLEAR_FILE: begin
			write_file  = 1'b1;
			update_zero = 1'b1;
			zero_val    = 1'b1;
		end
		`BOPBR_OP_DEC_FILE: begin
			result      = file_val - 8'h01;
			write_work  = (dest_sel == `BOPBR_DEST_WORK);
			write_file  = (dest_sel == `BOPBR_DEST_FILE);
			update_zero = 1'b1;
			zero_val    = is_zero(result);
		end
		`BOPBR_OP_CLEAR_WORK: begin
			write_work  = 1'b1;
			update_zero = 1'b1;
			zero_val    = 1'b1;
		end
		`BOPBR_OP_DEC_SKIP: begin
			// Flags stay untouched: update_zero remains low
			result      = file_val - 8'h01;
			write_work  = (dest_sel == `BOPBR_DEST_WORK);
			write_file  = (dest_sel == `BOPBR_DEST_FILE);
			skip_next   = is_zero(result);
		end
		`BOPBR_OP_INC_SKIP: begin
			result      = file_val + 8'h01;
			write_work  = (dest_sel == `BOPBR_DEST_WORK);
			write_file  = (dest_sel == `BOPBR_DEST_FILE);
			skip_next   = is_zero(result);
		end
		`BOPBR_OP_OR_LITERAL: begin
			result      = work_val | lit_val;
			write_work  = 1'b1;
			update_zero = 1'b1;
			zero_val    = is_zero(result);
		end
		default: begin
			result      = `BOPBR_RST_DATA;
		end
		endcase
	end

endmodule

//--- rtl/bopbr_core.v
// Execution unit for clear, decrement, skip, branch and OR-literal ops
`timescale 1ns/1ps
`include "bopbr_defines.vh"

module bopbr_core #(
	parameter FILE_DEPTH = `BOPBR_FILE_DEPTH
) (
	mclk,
	rstn,
	instr_valid,
	op_sel,
	f_addr,
	dest_sel,
	literal_k,
	program_counter_latch_high,
	dbg_addr,
	instr_ready,
	retire,
	nop_cycle,
	working_reg,
	zero_flag,
	pc_out,
	dbg_data
);
	input  wire                        mclk;
	input  wire                        rstn;
	input  wire                        instr_valid;
	input  wire [2:0]                  op_sel;
	input  wire [`BOPBR_FADDR_W-1:0]   f_addr;
	input  wire                        dest_sel;
	input  wire [`BOPBR_LIT_W-1:0]     literal_k;
	input  wire [`BOPBR_LATCH_W-1:0]   program_counter_latch_high;
	input  wire [`BOPBR_FADDR_W-1:0]   dbg_addr;
	output wire                        instr_ready;
	output wire                        retire;
	output wire                        nop_cycle;
	output wire [`BOPBR_DATA_W-1:0]    working_reg;
	output wire                        zero_flag;
	output wire [`BOPBR_PC_W-1:0]      pc_out;
	output wire [`BOPBR_DATA_W-1:0]    dbg_data;

	// ************************************************************
	// State encoding
	// ************************************************************
	localparam [1:0] ST_EXEC = 2'b01;
	localparam [1:0] ST_NOP  = 2'b10;

	// ************************************************************
	// Storage
	// ************************************************************
	// All inputs come from logic on mclk, so none is synchronised.
	reg  [`BOPBR_DATA_W-1:0]   file_q [0:FILE_DEPTH-1];
	reg  [1:0]                 state_q;
	reg  [1:0]                 state_d;
	reg                        ready_q;
	reg                        ready_d;
	reg                        retire_q;
	reg                        nop_q;
	reg  [`BOPBR_DATA_W-1:0]   w_q;
	reg  [`BOPBR_DATA_W-1:0]   w_d;
	reg                        z_q;
	reg                        z_d;
	reg  [`BOPBR_PC_W-1:0]     pc_q;
	reg  [`BOPBR_PC_W-1:0]     pc_d;
	reg  [`BOPBR_DATA_W-1:0]   dbg_q;

	wire                       accept;
	wire [`BOPBR_DATA_W-1:0]   file_val;
	wire [`BOPBR_DATA_W-1:0]   alu_result;
	wire                       alu_write_work;
	wire                       alu_write_file;
	wire                       alu_update_zero;
	wire                       alu_zero_val;
	wire                       alu_skip;
	wire                       is_branch;
	wire                       long_op;
	wire [`BOPBR_PC_W-1:0]     branch_target;

	// An instruction is only taken while no no-op cycle is pending
	assign accept    = instr_valid & ready_q & (state_q == ST_EXEC);
	assign file_val  = file_q[f_addr];
	assign is_branch = (op_sel == `BOPBR_OP_BRANCH);

	// Branch and a taken skip both need the second cycle
	assign long_op   = is_branch | alu_skip;

	assign branch_target = {
		program_counter_latch_high[`BOPBR_LATCH_HI:`BOPBR_LATCH_LO],
		literal_k
	};

	// ************************************************************
	// Operation datapath
	// ************************************************************
	bopbr_alu u_alu (
		.op_sel      (op_sel),
		.work_val    (w_q),
		.file_val    (file_val),
		.lit_val     (literal_k[`BOPBR_DATA_W-1:0]),
		.dest_sel    (dest_sel),
		.result      (alu_result),
		.write_work  (alu_write_work),
		.write_file  (alu_write_file),
		.update_zero (alu_update_zero),
		.zero_val    (alu_zero_val),
		.skip_next   (alu_skip)
	);

	// ************************************************************
	// Next-state logic
	// ************************************************************
	always @* begin
		state_d = state_q;
		ready_d = ready_q;
		w_d     = w_q;
		z_d     = z_q;
		pc_d    = pc_q;
		case (state_q)
		ST_EXEC: begin
			if (accept) begin
				if (alu_write_work) begin
					w_d = alu_result;
				end
				// Skip ops and the branch leave update_zero low
				if (alu_update_zero) begin
					z_d = alu_zero_val;
				end
				if (is_branch) begin
					pc_d = branch_target;
				end else if (alu_skip) begin
					// Skipped word is stepped over at once: the PC advances by two when an accepted skip op gives a zero result
					pc_d = pc_q + 15'h0002;
				end else begin
					pc_d = pc_q + 15'h0001;
				end
				if (long_op) begin
					state_d = ST_NOP;
					ready_d = 1'b0;
				end
			end
		end
		ST_NOP: begin
			// Filler cycle: nothing architectural changes
			state_d = ST_EXEC;
			ready_d = 1'b1;
		end
		default: begin
			state_d = ST_EXEC;
			ready_d = 1'b1;
		end
		endcase
	end

	// ************************************************************
	// Control and architectural registers
	// ************************************************************
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			state_q  <= ST_EXEC;
			ready_q  <= 1'b1;
			retire_q <= 1'b0;
			nop_q    <= 1'b0;
			w_q      <= `BOPBR_RST_DATA;
			z_q      <= `BOPBR_RST_ZERO;
			pc_q     <= `BOPBR_RST_PC;
			dbg_q    <= `BOPBR_RST_DATA;
		end else begin
			state_q  <= state_d;
			ready_q  <= ready_d;
			retire_q <= accept;
			nop_q    <= (state_d == ST_NOP);
			w_q      <= w_d;
			z_q      <= z_d;
			pc_q     <= pc_d;
			dbg_q    <= file_q[dbg_addr];
		end
	end

	// ************************************************************
	// File registers
	// ************************************************************
	// One write port only; a flop array keeps the read combinational
	// at the cost of area for the full 128-entry file.
	genvar gi;
	generate
		for (gi = 0; gi < FILE_DEPTH; gi = gi + 1) begin : g_file
			always @(posedge mclk or negedge rstn) begin
				if (!rstn) begin
					file_q[gi] <= `BOPBR_RST_DATA;
				end else if (accept && alu_write_file &&
						(f_addr == gi)) begin
					file_q[gi] <= alu_result;
				end
			end
		end
	endgenerate

	// ************************************************************
	// Outputs
	// ************************************************************
	assign instr_ready = ready_q;
	assign retire      = retire_q;
	assign nop_cycle   = nop_q;
	assign working_reg = w_q;
	assign zero_flag   = z_q;
	assign pc_out      = pc_q;
	assign dbg_data    = dbg_q;

endmodule

//--- bench/bopbr_props.sv
// Port-level assertions for the execution unit
`timescale 1ns/1ps
`include "bopbr_defines.vh"
module bopbr_props #(
	parameter FILE_DEPTH = `BOPBR_FILE_DEPTH
) (
	input wire        mclk,
	input wire        rstn,
	input wire        instr_valid,
	input wire [2:0]  op_sel,
	input wire [6:0]  f_addr,
	input wire        dest_sel,
	input wire [10:0] literal_k,
	input wire [6:0]  program_counter_latch_high,
	input wire [6:0]  dbg_addr,
	input wire        instr_ready,
	input wire        retire,
	input wire        nop_cycle,
	input wire [7:0]  working_reg,
	input wire        zero_flag,
	input wire [14:0] pc_out,
	input wire [7:0]  dbg_data
);
	// ************************************************************
	// Checks for each operation but the empty one; branch and skip get two each
	// ************************************************************
	wire take = instr_valid && instr_ready;
	wire skip = op_sel == `BOPBR_OP_DEC_SKIP || op_sel == `BOPBR_OP_INC_SKIP;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);
	property p_clr_file;
		take && op_sel == `BOPBR_OP_CLEAR_FILE |=>
			zero_flag && pc_out == $past(pc_out) + 15'h0001;
	endproperty
	a_clr_file: assert property (p_clr_file)
		else $error("clear-file: zero flag or pc wrong");
	property p_dec_zero;
		take && op_sel == `BOPBR_OP_DEC_FILE && !dest_sel |=>
			zero_flag == (working_reg == 8'h00);
	endproperty
	a_dec_zero: assert property (p_dec_zero)
		else $error("decrement: zero flag does not follow result");
	property p_clr_work;
		take && op_sel == `BOPBR_OP_CLEAR_WORK |=>
			working_reg == 8'h00 && zero_flag;
	endproperty
	a_clr_work: assert property (p_clr_work)
		else $error("clear-working: W or zero flag wrong");
	property p_skip_flag;
		take && skip |=> $stable(zero_flag);
	endproperty
	a_skip_flag: assert property (p_skip_flag)
		else $error("skip op changed the zero flag");
	property p_skip_nop;
		take && skip && !dest_sel |=> nop_cycle == (working_reg == 8'h00);
	endproperty
	a_skip_nop: assert property (p_skip_nop)
		else $error("skip op filler cycle does not match result");
	property p_br_pc;
		take && op_sel == `BOPBR_OP_BRANCH |=> pc_out ==
			{$past(program_counter_latch_high[6:3]), $past(literal_k)};
	endproperty
	a_br_pc: assert property (p_br_pc)
		else $error("branch target wrong");
	property p_br_two;
		take && op_sel == `BOPBR_OP_BRANCH |=> nop_cycle && !instr_ready
			&& $stable(zero_flag) ##1 instr_ready && !nop_cycle;
	endproperty
	a_br_two: assert property (p_br_two)
		else $error("branch is not two cycles or touched zero flag");
	property p_or_lit;
		take && op_sel == `BOPBR_OP_OR_LITERAL |=> working_reg ==
			($past(working_reg) | $past(literal_k[7:0]))
			&& zero_flag == (working_reg == 8'h00);
	endproperty
	a_or_lit: assert property (p_or_lit)
		else $error("OR-literal result or zero flag wrong");
	c_branch: cover property (take && op_sel == `BOPBR_OP_BRANCH);
	c_skip: cover property (take && skip ##1 nop_cycle);
	c_or_zero: cover property (take && op_sel == `BOPBR_OP_OR_LITERAL
		##1 zero_flag);
endmodule

bind bopbr_core bopbr_props #(.FILE_DEPTH(FILE_DEPTH)) u_props (
	.mclk(mclk), .rstn(rstn), .instr_valid(instr_valid),
	.op_sel(op_sel), .f_addr(f_addr), .dest_sel(dest_sel),
	.literal_k(literal_k), .dbg_addr(dbg_addr),
	.program_counter_latch_high(program_counter_latch_high),
	.instr_ready(instr_ready), .retire(retire), .nop_cycle(nop_cycle),
	.working_reg(working_reg), .zero_flag(zero_flag), .pc_out(pc_out),
	.dbg_data(dbg_data)
);

//--- bench/byte_op_branch_subset_tb.sv
// Self-checking bench for the byte-op and branch execution unit
`timescale 1ns/1ps
`include "bopbr_defines.vh"
module byte_op_branch_subset_tb;
	logic        mclk;
	logic        rstn;
	logic        instr_valid;
	logic [2:0]  op_sel;
	logic [6:0]  f_addr;
	logic        dest_sel;
	logic [10:0] literal_k;
	logic [6:0]  program_counter_latch_high;
	logic [6:0]  dbg_addr;
	wire         instr_ready;
	wire         retire;
	wire         nop_cycle;
	wire [7:0]   working_reg;
	wire         zero_flag;
	wire [14:0]  pc_out;
	wire [7:0]   dbg_data;
	logic [14:0] exp_pc;
	int          n_fail;
	int          n_checks;

	bopbr_core #(.FILE_DEPTH(128)) dut_u (
		.mclk(mclk), .rstn(rstn), .instr_valid(instr_valid),
		.op_sel(op_sel), .f_addr(f_addr), .dest_sel(dest_sel),
		.literal_k(literal_k), .dbg_addr(dbg_addr),
		.program_counter_latch_high(program_counter_latch_high),
		.instr_ready(instr_ready), .retire(retire), .nop_cycle(nop_cycle),
		.working_reg(working_reg), .zero_flag(zero_flag), .pc_out(pc_out),
		.dbg_data(dbg_data)
	);

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	// ************************************************************
	// Bus tasks
	// ************************************************************
	function automatic logic [14:0] b(input logic x);
		return {14'h0000, x};
	endfunction
	task automatic chk(input string nm, input logic [14:0] e, g);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Valid stays high afterwards so back-to-back issues never toggle it
	task automatic issue(input logic [2:0] op, input logic [6:0] a,
		input logic d, input logic [10:0] k);
		instr_valid = 1'b1;
		op_sel = op;
		f_addr = a;
		dest_sel = d;
		literal_k = k;
		@(posedge mclk);
		#1;
		chk("retire", b(1'b1), b(retire));
	endtask
	task automatic idle;
		instr_valid = 1'b0;
		@(posedge mclk);
		#1;
	endtask
	task automatic st(input logic [7:0] w, input logic z, input logic n);
		chk("working_reg", {7'h00, w}, {7'h00, working_reg});
		chk("zero_flag", b(z), b(zero_flag));
		chk("nop_cycle", b(n), b(nop_cycle));
		chk("pc_out", exp_pc, pc_out);
	endtask
	task automatic rd(input logic [6:0] a, input logic [7:0] e);
		dbg_addr = a;
		@(posedge mclk);
		#1;
		chk("file", {7'h00, e}, {7'h00, dbg_data});
	endtask

	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic t_literal;
		exp_pc = 15'h0000;
		st(8'h00, 1'b0, 1'b0);
		issue(`BOPBR_OP_OR_LITERAL, 7'h00, 1'b0, 11'h700);
		exp_pc = 15'h0001;
		st(8'h00, 1'b1, 1'b0);
		issue(`BOPBR_OP_OR_LITERAL, 7'h00, 1'b0, 11'h0a5);
		exp_pc = 15'h0002;
		st(8'ha5, 1'b0, 1'b0);
		issue(`BOPBR_OP_CLEAR_WORK, 7'h00, 1'b0, 11'h000);
		exp_pc = 15'h0003;
		st(8'h00, 1'b1, 1'b0);
		issue(`BOPBR_OP_OR_LITERAL, 7'h00, 1'b0, 11'h001);
		exp_pc = 15'h0004;
		st(8'h01, 1'b0, 1'b0);
	endtask
	task automatic t_file;
		issue(`BOPBR_OP_CLEAR_FILE, 7'h7f, 1'b0, 11'h000);
		exp_pc = 15'h0005;
		st(8'h01, 1'b1, 1'b0);
		issue(`BOPBR_OP_DEC_FILE, 7'h7f, 1'b1, 11'h000);
		exp_pc = 15'h0006;
		st(8'h01, 1'b0, 1'b0);
		issue(`BOPBR_OP_DEC_FILE, 7'h7f, 1'b0, 11'h000);
		exp_pc = 15'h0007;
		st(8'hfe, 1'b0, 1'b0);
		issue(`BOPBR_OP_CLEAR_FILE, 7'h05, 1'b0, 11'h000);
		exp_pc = 15'h0008;
		idle;
		rd(7'h7f, 8'hff);
	endtask
	task automatic t_skip;
		issue(`BOPBR_OP_INC_SKIP, 7'h05, 1'b1, 11'h000);
		exp_pc = 15'h0009;
		st(8'hfe, 1'b1, 1'b0);
		issue(`BOPBR_OP_OR_LITERAL, 7'h00, 1'b0, 11'h000);
		exp_pc = 15'h000a;
		issue(`BOPBR_OP_DEC_SKIP, 7'h05, 1'b0, 11'h000);
		exp_pc = 15'h000c;
		st(8'h00, 1'b0, 1'b1);
		idle;
		rd(7'h05, 8'h01);
		issue(`BOPBR_OP_INC_SKIP, 7'h7f, 1'b1, 11'h000);
		exp_pc = 15'h000e;
		st(8'h00, 1'b0, 1'b1);
		idle;
		rd(7'h7f, 8'h00);
	endtask
	task automatic t_branch;
		issue(`BOPBR_OP_OR_LITERAL, 7'h00, 1'b0, 11'h03c);
		program_counter_latch_high = 7'h4f;
		issue(`BOPBR_OP_BRANCH, 7'h00, 1'b0, 11'h7ff);
		exp_pc = 15'h4fff;
		st(8'h3c, 1'b0, 1'b1);
		chk("instr_ready", b(1'b0), b(instr_ready));
		// Offered in the filler cycle, so it must be dropped
		op_sel = `BOPBR_OP_CLEAR_WORK;
		@(posedge mclk);
		#1;
		instr_valid = 1'b0;
		chk("retire", b(1'b0), b(retire));
		st(8'h3c, 1'b0, 1'b0);
		// Empty operation only steps the program counter
		issue(`BOPBR_OP_NONE, 7'h00, 1'b0, 11'h000);
		exp_pc = 15'h5000;
		st(8'h3c, 1'b0, 1'b0);
	endtask
	// Reset in mid-run must clear the file registers as well
	task automatic t_reset;
		rstn = 1'b0;
		instr_valid = 1'b0;
		#1;
		exp_pc = 15'h0000;
		st(8'h00, 1'b0, 1'b0);
		chk("instr_ready", b(1'b1), b(instr_ready));
		chk("retire", b(1'b0), b(retire));
		chk("dbg_data", 15'h0000, {7'h00, dbg_data});
		@(posedge mclk);
		#1;
		rstn = 1'b1;
		rd(7'h05, 8'h00);
		st(8'h00, 1'b0, 1'b0);
	endtask

	task automatic final_report;
		$display("checks %0d failures %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		n_fail = 0;
		n_checks = 0;
		rstn = 1'b0;
		instr_valid = 1'b0;
		op_sel = 3'h0;
		f_addr = 7'h00;
		dest_sel = 1'b0;
		literal_k = 11'h000;
		program_counter_latch_high = 7'h00;
		dbg_addr = 7'h00;
		repeat (10) @(posedge mclk);
		#1;
		rstn = 1'b1;
		t_literal;
		t_file;
		t_skip;
		t_branch;
		t_reset;
		final_report;
	end

	// The run needs under 60 cycles; 1000 leaves room without hiding a hang
	initial begin
		#20000;
		n_fail++;
		final_report;
	end
endmodule
